// ===== include/tvps_pkg.sv
package tvps_pkg;
  // instruction opcodes held in program memory
  typedef enum logic [3:0] {
    TVPS_OP_END     = 4'h0,
    TVPS_OP_LD_IDX  = 4'h1,
    TVPS_OP_LD_MASK = 4'h2,
    TVPS_OP_LD_STOP = 4'h3,
    TVPS_OP_LD_MODE = 4'h4,
    TVPS_OP_JP_IMM  = 4'h5,
    TVPS_OP_JP_IDX  = 4'h6,
    TVPS_OP_GR      = 4'h7,
    TVPS_OP_SECT    = 4'h8,
    TVPS_OP_SIL     = 4'h9,
    TVPS_OP_SEQEND  = 4'ha
  } tvps_op_t;

  // condition codes: 0 none, 1 last pass, 8..15 trigger level (bit2:1 trigger, bit0 level)
  localparam logic [3:0] TVPS_CND_NONE = 4'h0;
  localparam logic [3:0] TVPS_CND_LAST = 4'h1;

  // one 32-bit instruction word: op, cond, 8-bit operand, 16-bit extra
  typedef struct packed {
    tvps_op_t op;
    logic [3:0] cnd;
    logic [7:0] arg;
    logic [15:0] ext;
  } tvps_ins_t;

  // rate and lamp fields of a section word live in ext
  localparam int TVPS_SEC_RATE_LSB = 0;
  localparam int TVPS_SEC_LAMP_BIT = 2;
  localparam int TVPS_SEC_LREP_LSB = 4;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] stop;
    logic [7:0] mode;
    logic [7:0] idx;
  } tvps_regs_t;

  localparam logic [7:0] TVPS_MASK_RST = 8'hff;
  localparam logic [7:0] TVPS_STOP_RST = 8'h07;
  localparam logic [7:0] TVPS_MODE_RST = 8'hf0;
  localparam logic [7:0] TVPS_IDX_RST = 8'h00;

  localparam int TVPS_MODE_FLASH = 7;
  localparam int TVPS_MODE_P4LAMP = 6;
  localparam int TVPS_MODE_P4TRIG = 5;
  localparam int TVPS_MODE_LONGDB = 4;

  localparam logic [7:0] TVPS_POWERUP_GROUP = 8'h20;
  localparam int TVPS_HW_GROUPS = 8;

  localparam longint TVPS_CLK_HZ = 250000000;
  localparam longint TVPS_DB_LONG_US = 45000;
  localparam longint TVPS_DB_SHORT_NS = 350000;
  localparam longint TVPS_POR_MS = 160;
  localparam longint TVPS_FLASH_HZ = 3;
  localparam longint TVPS_DB_LONG_CYC = TVPS_DB_LONG_US * (TVPS_CLK_HZ / 1000000);
  localparam longint TVPS_DB_SHORT_CYC = (TVPS_DB_SHORT_NS * (TVPS_CLK_HZ / 1000000) + 999) / 1000;
  localparam longint TVPS_POR_CYC = TVPS_POR_MS * (TVPS_CLK_HZ / 1000);
  localparam longint TVPS_FLASH_HALF_CYC = TVPS_CLK_HZ / (2 * TVPS_FLASH_HZ);
  // sample rate per rate code: 4, 4.8, 6, 8 kHz
  localparam longint TVPS_RATE_HZ_0 = 4000;
  localparam longint TVPS_RATE_HZ_1 = 4800;
  localparam longint TVPS_RATE_HZ_2 = 6000;
  localparam longint TVPS_RATE_HZ_3 = 8000;
endpackage

// ===== verilog/tvps_sequencer.sv
// Behaviour
// RULE_01: an enabled trigger edge aborts the running group and starts its hardware group
// RULE_02: an edge whose mask bit is zero does nothing; playback continues
// RULE_03: falling edges 1-4 enter groups 0-3, rising edges groups 4-7
// RULE_04: stop bits 0,1,2 drive level outputs a,b,c; one is high
// RULE_05: after reset the three used stop bits are ones
// RULE_06: mode bits 7..4 each pick first option when one; bits 3..0 unused
// RULE_07: after reset mode bits 7..4 are ones
// RULE_08: mode bit5 one makes pin4 trigger 4; else lamp 2 or level c by bit6
// RULE_09: mode bit7 one flashes lamp at 3 Hz in playback; zero keeps it lit
// RULE_10: mode bit4 picks debounce of 45 ms when one, 350 us when zero
// RULE_11: direct jump goes to immediate group 0..127
// RULE_12: indirect jump goes to the group in the voice index register
// RULE_13: conditional load or jump runs only when its condition holds; the mode load here ignores its condition
// RULE_14: last-pass condition is true only on final global repeat pass
// RULE_15: trigger-level condition tests present level of the named trigger
// RULE_16: end instruction stops all activity immediately including playback
// RULE_17: execution starts at a group entry and runs sequentially to end
// RULE_18: sequence plays global repeat times; each section its local repeat times
// RULE_19: section rate code picks 4, 4.8, 6 or 8 kHz sample rate
// RULE_20: section lamp bit turns the lamp on for that section
// RULE_21: silence item outputs nothing for its count of samples
// RULE_22: after about 160 ms at power-up run group 32; edges may interrupt
// RULE_23: mask bits 7..4 enable rising edges 4..1, bits 3..0 falling edges
// RULE_24: voice index register resets to zero and loads 0..255
// RULE_25: after reset every mask bit is one
// RULE_26: after end the device idles with outputs held until an enabled edge
// RULE_27: edges count only after the level is stable for the debounce time
module tvps_sequencer
  import tvps_pkg::*;
#(
  parameter int PROG_DEPTH = 256,
  parameter int PC_W = 8,
  parameter int DB_LONG_CYC = int'(TVPS_DB_LONG_CYC),
  parameter int DB_SHORT_CYC = int'(TVPS_DB_SHORT_CYC),
  parameter int POR_CYC = int'(TVPS_POR_CYC),
  parameter int FLASH_HALF_CYC = int'(TVPS_FLASH_HALF_CYC)
)
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic CLK_EN_I,
  input wire logic [3:0] TRIG_I,
  input wire logic PROG_WE_I,
  input wire logic [PC_W-1:0] PROG_ADDR_I,
  input wire logic [31:0] PROG_DATA_I,
  input wire logic [PC_W-1:0] GROUP_BASE_WE_IDX_I,
  input wire logic GROUP_BASE_WE_I,
  input wire logic [PC_W-1:0] GROUP_BASE_I,
  output logic LEVEL_A_O,
  output logic LEVEL_B_O,
  output logic LAMP1_O,
  output logic PIN4_O,
  output logic PIN4_OE_O,
  output logic PLAYING_O,
  output logic SAMPLE_TICK_O,
  output logic [1:0] RATE_O
);
  localparam int DB_W = 32;

  typedef enum logic [2:0] {
    TVPS_ST_POR = 3'b000,
    TVPS_ST_IDLE = 3'b001,
    TVPS_ST_FETCH = 3'b010,
    TVPS_ST_EXEC = 3'b011,
    TVPS_ST_PLAY = 3'b100
  } tvps_state_t;

  tvps_state_t st_q;
  tvps_regs_t regs_q;
  tvps_ins_t prog_q [PROG_DEPTH];
  logic [PC_W-1:0] base_q [256];
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] seq_start_q;
  logic [4:0] gr_left_q;
  logic [2:0] lrep_left_q;
  logic [15:0] len_left_q;
  logic [31:0] tick_cnt_q;
  logic [31:0] por_cnt_q;
  logic [3:0] trig_s1_q;
  logic [3:0] trig_s2_q;
  logic [3:0] trig_db_q;
  logic [3:0] trig_prev_q;
  logic [DB_W-1:0] db_cnt_q [4];
  logic [31:0] flash_cnt_q;
  logic flash_q;
  logic sect_lamp_q;
  logic silent_q;
  logic [1:0] rate_q;
  tvps_ins_t ins;
  logic [7:0] edge_vec;
  logic hit;
  logic [2:0] hit_grp;
  logic cond_ok;
  logic [31:0] rate_cyc;
  logic [DB_W-1:0] db_lim;

  assign ins = prog_q[pc_q];

  // program memory and group entry table are loaded by the host-side loader
  always_ff @(posedge CLK_SYS_I)
  begin
    if (CLK_EN_I && PROG_WE_I)
    begin
      prog_q[PROG_ADDR_I] <= PROG_DATA_I;
    end
    if (CLK_EN_I && GROUP_BASE_WE_I)
    begin
      base_q[GROUP_BASE_WE_IDX_I] <= GROUP_BASE_I;
    end
  end

  // two-flop pin synchroniser
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      trig_s1_q <= 4'hf;
      trig_s2_q <= 4'hf;
    end
    else if (CLK_EN_I)
    begin
      trig_s1_q <= TRIG_I;
      trig_s2_q <= trig_s1_q;
    end
  end

  assign db_lim = regs_q.mode[TVPS_MODE_LONGDB] ? DB_W'(DB_LONG_CYC) : DB_W'(DB_SHORT_CYC); // RULE_10

  // per-trigger debounce: a new level is accepted only once it held for db_lim cycles
  for (genvar g = 0; g < 4; g++)
  begin : g_db
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
      if (!RST_B_I)
      begin
        db_cnt_q[g] <= '0;
        trig_db_q[g] <= 1'b1;
        trig_prev_q[g] <= 1'b1;
      end
      else if (CLK_EN_I)
      begin
        trig_prev_q[g] <= trig_db_q[g];
        if (trig_s2_q[g] == trig_db_q[g])
        begin
          db_cnt_q[g] <= '0;
        end
        else if (db_cnt_q[g] + 1'b1 >= db_lim)
        begin
          db_cnt_q[g] <= '0;
          trig_db_q[g] <= trig_s2_q[g]; // RULE_27
        end
        else
        begin
          db_cnt_q[g] <= db_cnt_q[g] + 1'b1;
        end
      end
    end
    // falling edge in bit g, rising in g+4; trigger 4 only when pin4 is an input
    assign edge_vec[g] = trig_prev_q[g] & ~trig_db_q[g] & ((g != 3) | regs_q.mode[TVPS_MODE_P4TRIG]); // RULE_08
    assign edge_vec[g+4] = ~trig_prev_q[g] & trig_db_q[g] & ((g != 3) | regs_q.mode[TVPS_MODE_P4TRIG]);
  end

  // lowest enabled edge wins when several settle in one cycle
  always_comb
  begin
    hit = 1'b0;
    hit_grp = 3'h0;
    for (int i = TVPS_HW_GROUPS - 1; i >= 0; i--)
    begin
      if (edge_vec[i] && regs_q.mask[i]) // RULE_02 RULE_23
      begin
        hit = 1'b1;
        hit_grp = 3'(i); // RULE_03
      end
    end
  end

  always_comb
  begin
    cond_ok = 1'b1;
    if (ins.cnd == TVPS_CND_LAST)
    begin
      cond_ok = (gr_left_q == 5'h1); // RULE_14
    end
    else if (ins.cnd[3])
    begin
      cond_ok = (trig_db_q[ins.cnd[2:1]] == ins.cnd[0]); // RULE_15
    end
  end

  always_comb
  begin
    case (rate_q) // RULE_19
      2'h0: rate_cyc = 32'(TVPS_CLK_HZ / TVPS_RATE_HZ_0);
      2'h1: rate_cyc = 32'(TVPS_CLK_HZ / TVPS_RATE_HZ_1);
      2'h2: rate_cyc = 32'(TVPS_CLK_HZ / TVPS_RATE_HZ_2);
      default: rate_cyc = 32'(TVPS_CLK_HZ / TVPS_RATE_HZ_3);
    endcase
  end

  // sequencer: one instruction per fetch/exec pair, playback counts samples
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      st_q <= TVPS_ST_POR;
      pc_q <= '0;
      seq_start_q <= '0;
      regs_q <= '{mask: TVPS_MASK_RST, stop: TVPS_STOP_RST, mode: TVPS_MODE_RST, idx: TVPS_IDX_RST}; // RULE_05 RULE_07 RULE_24 RULE_25
      gr_left_q <= 5'h1;
      lrep_left_q <= 3'h0;
      len_left_q <= '0;
      tick_cnt_q <= '0;
      por_cnt_q <= '0;
      sect_lamp_q <= 1'b0;
      silent_q <= 1'b0;
      rate_q <= 2'h0;
    end
    else if (CLK_EN_I)
    begin
      if (hit && st_q != TVPS_ST_POR)
      begin
        // abort immediately; power-up program may be cut short too
        pc_q <= base_q[8'(hit_grp)]; // RULE_01 RULE_22
        st_q <= TVPS_ST_FETCH;
        sect_lamp_q <= 1'b0;
        gr_left_q <= 5'h1;
      end
      else
      begin
        case (st_q)
          TVPS_ST_POR:
          begin
            if (por_cnt_q + 1 >= 32'(POR_CYC))
            begin
              pc_q <= base_q[TVPS_POWERUP_GROUP]; // RULE_22
              st_q <= TVPS_ST_FETCH;
            end
            else
            begin
              por_cnt_q <= por_cnt_q + 1;
            end
          end
          TVPS_ST_IDLE:
          begin
            st_q <= TVPS_ST_IDLE; // RULE_26
          end
          TVPS_ST_FETCH:
          begin
            st_q <= TVPS_ST_EXEC;
          end
          TVPS_ST_EXEC:
          begin
            pc_q <= pc_q + 1'b1; // RULE_17
            st_q <= TVPS_ST_FETCH;
            case (ins.op)
              TVPS_OP_END:
              begin
                st_q <= TVPS_ST_IDLE; // RULE_16
                sect_lamp_q <= 1'b0;
                pc_q <= pc_q;
              end
              TVPS_OP_LD_IDX:
                if (cond_ok) regs_q.idx <= ins.arg; // RULE_13
              TVPS_OP_LD_MASK:
                if (cond_ok) regs_q.mask <= ins.arg;
              TVPS_OP_LD_STOP:
                if (cond_ok) regs_q.stop <= ins.arg;
              TVPS_OP_LD_MODE:
                regs_q.mode <= ins.arg; // RULE_06
              TVPS_OP_JP_IMM:
                if (cond_ok) pc_q <= base_q[{1'b0, ins.arg[6:0]}]; // RULE_11
              TVPS_OP_JP_IDX:
                if (cond_ok) pc_q <= base_q[regs_q.idx]; // RULE_12
              TVPS_OP_GR:
              begin
                gr_left_q <= 5'(ins.arg[3:0]) + 5'h1; // RULE_18
                seq_start_q <= pc_q + 1'b1;
              end
              TVPS_OP_SECT, TVPS_OP_SIL:
              begin
                silent_q <= (ins.op == TVPS_OP_SIL); // RULE_21
                rate_q <= ins.ext[TVPS_SEC_RATE_LSB +: 2];
                sect_lamp_q <= (ins.op == TVPS_OP_SECT) && ins.ext[TVPS_SEC_LAMP_BIT]; // RULE_20
                lrep_left_q <= (ins.op == TVPS_OP_SIL) ? 3'h1 : ins.ext[TVPS_SEC_LREP_LSB +: 3];
                len_left_q <= (ins.op == TVPS_OP_SIL) ? ins.ext : {8'h00, ins.arg};
                tick_cnt_q <= '0;
                pc_q <= pc_q;
                st_q <= TVPS_ST_PLAY;
              end
              TVPS_OP_SEQEND:
              begin
                if (gr_left_q > 5'h1)
                begin
                  gr_left_q <= gr_left_q - 5'h1; // RULE_18
                  pc_q <= seq_start_q;
                end
              end
              default:
              begin
                st_q <= TVPS_ST_IDLE;
              end
            endcase
          end
          TVPS_ST_PLAY:
          begin
            if (tick_cnt_q + 1 >= rate_cyc)
            begin
              tick_cnt_q <= '0;
              if (len_left_q <= 16'h1)
              begin
                if (lrep_left_q <= 3'h1)
                begin
                  pc_q <= pc_q + 1'b1;
                  sect_lamp_q <= 1'b0;
                  st_q <= TVPS_ST_FETCH;
                end
                else
                begin
                  lrep_left_q <= lrep_left_q - 3'h1; // RULE_18
                  len_left_q <= {8'h00, ins.arg};
                end
              end
              else
              begin
                len_left_q <= len_left_q - 16'h1;
              end
            end
            else
            begin
              tick_cnt_q <= tick_cnt_q + 1;
            end
          end
          default:
          begin
            st_q <= TVPS_ST_IDLE;
          end
        endcase
      end
    end
  end

  // free-running 3 Hz flash phase
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      flash_cnt_q <= '0;
      flash_q <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      if (flash_cnt_q + 1 >= 32'(FLASH_HALF_CYC))
      begin
        flash_cnt_q <= '0;
        flash_q <= ~flash_q;
      end
      else
      begin
        flash_cnt_q <= flash_cnt_q + 1;
      end
    end
  end

  // registered outputs; lamp follows section bit, flashing when selected
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      LEVEL_A_O <= TVPS_STOP_RST[0];
      LEVEL_B_O <= TVPS_STOP_RST[1];
      LAMP1_O <= 1'b0;
      PIN4_O <= 1'b0;
      PIN4_OE_O <= 1'b0;
      PLAYING_O <= 1'b0;
      SAMPLE_TICK_O <= 1'b0;
      RATE_O <= 2'h0;
    end
    else if (CLK_EN_I)
    begin
      LEVEL_A_O <= regs_q.stop[0]; // RULE_04
      LEVEL_B_O <= regs_q.stop[1];
      LAMP1_O <= sect_lamp_q && (!regs_q.mode[TVPS_MODE_FLASH] || flash_q); // RULE_09
      PIN4_OE_O <= !regs_q.mode[TVPS_MODE_P4TRIG]; // RULE_08
      PIN4_O <= regs_q.mode[TVPS_MODE_P4LAMP]
        ? (sect_lamp_q && (!regs_q.mode[TVPS_MODE_FLASH] || flash_q))
        : regs_q.stop[2]; // RULE_04
      PLAYING_O <= (st_q == TVPS_ST_PLAY) && !silent_q;
      SAMPLE_TICK_O <= (st_q == TVPS_ST_PLAY) && (tick_cnt_q + 1 >= rate_cyc) && !silent_q;
      RATE_O <= rate_q;
    end
  end
endmodule // tvps_sequencer

// ===== dv/tvps_chk.sv
module tvps_chk
  import tvps_pkg::*;
#(
  parameter int POR_CYC = 100
)
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic CLK_EN_I,
  input wire logic [3:0] TRIG_I,
  input wire logic LEVEL_A_O,
  input wire logic LEVEL_B_O,
  input wire logic LAMP1_O,
  input wire logic PIN4_O,
  input wire logic PIN4_OE_O,
  input wire logic PLAYING_O,
  input wire logic SAMPLE_TICK_O,
  input wire logic [1:0] RATE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  // margin of two cycles covers the fetch and the output lag
  int unsigned por_q;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      por_q <= 0;
    else if (por_q < POR_CYC)
      por_q <= por_q + 1;
  end
  a_rst_levels: assert property ($rose(RST_B_I) |-> LEVEL_A_O && LEVEL_B_O)
    else $error("level outputs not high after reset");
  a_rst_pin4: assert property ($rose(RST_B_I) |-> !PIN4_OE_O && !PLAYING_O)
    else $error("pin4 driven or playing after reset");
  a_por_levels: assert property ((por_q + 2 < POR_CYC) |-> LEVEL_A_O && LEVEL_B_O)
    else $error("levels changed in power-up delay");
  a_por_quiet: assert property ((por_q + 2 < POR_CYC) |-> !PLAYING_O && !SAMPLE_TICK_O)
    else $error("playback in power-up delay");
  a_tick_gap: assert property (SAMPLE_TICK_O |=> !SAMPLE_TICK_O [*8])
    else $error("sample ticks too close");
  a_tick_play: assert property (SAMPLE_TICK_O |-> PLAYING_O || $past(PLAYING_O))
    else $error("sample tick outside a section");
  a_rate_hold: assert property ($rose(PLAYING_O) |=> $stable(RATE_O) [*4])
    else $error("rate moved inside a section");
  a_fall_gap: assert property ($fell(PLAYING_O) |=> !PLAYING_O)
    else $error("playback resumed at once after stop");
endmodule // tvps_chk

bind tvps_sequencer tvps_chk #(.POR_CYC(POR_CYC)) i_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .CLK_EN_I(CLK_EN_I), .TRIG_I(TRIG_I),
  .LEVEL_A_O(LEVEL_A_O), .LEVEL_B_O(LEVEL_B_O), .LAMP1_O(LAMP1_O), .PIN4_O(PIN4_O),
  .PIN4_OE_O(PIN4_OE_O), .PLAYING_O(PLAYING_O), .SAMPLE_TICK_O(SAMPLE_TICK_O), .RATE_O(RATE_O)
);

// ===== dv/tvps_buttons.sv
module tvps_buttons
(
  input wire logic [3:0] press_i,
  input wire logic pin4_i,
  input wire logic pin4_oe_i,
  output logic [3:0] trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released keys read high through the pull-ups
  assign trig_o[2:0] = ~press_i[2:0];
  // pin4 shows the device level while it drives, else the key
  assign trig_o[3] = pin4_oe_i ? pin4_i : ~press_i[3];
endmodule // tvps_buttons

// ===== dv/tb_top.sv
module tb_top;
  import tvps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic prog_we = 1'b0;
  logic [7:0] prog_addr = 8'h00;
  logic [31:0] prog_data = 32'h0;
  logic base_we = 1'b0;
  logic [7:0] base_idx = 8'h00;
  logic [7:0] base_adr = 8'h00;
  logic [3:0] press = 4'h0;
  logic [3:0] trig;
  logic lvl_a, lvl_b, lamp1, pin4, pin4_oe, playing, tick;
  logic [1:0] rate;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int ticks = 0;
  always #2 clk = ~clk;
  localparam int FLASH_HALF = 16;
  tvps_sequencer #(.POR_CYC(100), .DB_LONG_CYC(8), .DB_SHORT_CYC(4), .FLASH_HALF_CYC(FLASH_HALF)) i_dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .CLK_EN_I(1'b1), .TRIG_I(trig),
    .PROG_WE_I(prog_we), .PROG_ADDR_I(prog_addr), .PROG_DATA_I(prog_data),
    .GROUP_BASE_WE_IDX_I(base_idx), .GROUP_BASE_WE_I(base_we), .GROUP_BASE_I(base_adr),
    .LEVEL_A_O(lvl_a), .LEVEL_B_O(lvl_b), .LAMP1_O(lamp1), .PIN4_O(pin4),
    .PIN4_OE_O(pin4_oe), .PLAYING_O(playing), .SAMPLE_TICK_O(tick), .RATE_O(rate)
  );
  tvps_buttons i_btn (.press_i(press), .pin4_i(pin4), .pin4_oe_i(pin4_oe), .trig_o(trig));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // run is about 63k cycles; the ceiling leaves room for slow debounce
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tick === 1'b1)
      ticks <= ticks + 1;
    if (cyc == 90000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input tvps_op_t op, input logic [3:0] c, input logic [7:0] g,
                    input logic [15:0] e);
    @(posedge clk);
    prog_we <= 1'b1;
    prog_addr <= a;
    prog_data <= {op, c, g, e};
  endtask
  task automatic bs(input logic [7:0] g, input logic [7:0] a);
    @(posedge clk);
    base_we <= 1'b1;
    base_idx <= g;
    base_adr <= a;
  endtask
  // program words go in during the power-up delay
  task automatic t_load;
    bs(8'h20, 8'h00);
    bs(8'h00, 8'h04);
    bs(8'h0b, 8'h06);
    bs(8'h02, 8'h0a);
    bs(8'h06, 8'h10);
    bs(8'h04, 8'h12);
    bs(8'h0a, 8'h16);
    wr(8'h00, TVPS_OP_LD_STOP, 4'h0, 8'h02, 16'h0000);
    base_we <= 1'b0;
    wr(8'h01, TVPS_OP_END, 4'h0, 8'h00, 16'h0000);
    wr(8'h04, TVPS_OP_JP_IMM, 4'h0, 8'h0b, 16'h0000);
    wr(8'h06, TVPS_OP_LD_STOP, 4'h0, 8'h05, 16'h0000);
    wr(8'h07, TVPS_OP_LD_MODE, 4'h0, 8'h10, 16'h0000);
    wr(8'h08, TVPS_OP_END, 4'h0, 8'h00, 16'h0000);
    wr(8'h0a, TVPS_OP_GR, 4'h0, 8'h00, 16'h0000);
    wr(8'h0b, TVPS_OP_SECT, 4'h0, 8'h01, 16'h0027);
    wr(8'h0c, TVPS_OP_SEQEND, 4'h0, 8'h00, 16'h0000);
    wr(8'h0d, TVPS_OP_END, 4'h0, 8'h00, 16'h0000);
    wr(8'h10, TVPS_OP_LD_MODE, 4'h0, 8'hc0, 16'h0000);
    wr(8'h11, TVPS_OP_JP_IMM, 4'h0, 8'h02, 16'h0000);
    wr(8'h12, TVPS_OP_LD_MASK, 4'h0, 8'h01, 16'h0000);
    wr(8'h13, TVPS_OP_LD_IDX, 4'h1, 8'h0a, 16'h0000);
    wr(8'h14, TVPS_OP_JP_IDX, 4'h0, 8'h00, 16'h0000);
    wr(8'h16, TVPS_OP_LD_STOP, 4'h9, 8'h03, 16'h0000);
    wr(8'h17, TVPS_OP_LD_STOP, 4'h8, 8'h00, 16'h0000);
    wr(8'h18, TVPS_OP_END, 4'h0, 8'h00, 16'h0000);
    @(posedge clk);
    prog_we <= 1'b0;
  endtask
  task automatic t_por;
    wait_n(100);
    chk(8'({lvl_b, lvl_a}), 8'h02);
    chk(8'(pin4_oe), 8'h00);
    $display("power-up test done");
  endtask
  // a six-cycle glitch stays under the long debounce of eight cycles
  task automatic t_jump;
    press[0] <= 1'b1;
    wait_n(6);
    press[0] <= 1'b0;
    wait_n(30);
    chk(8'({lvl_b, lvl_a}), 8'h02);
    press[0] <= 1'b1;
    wait_n(40);
    chk(8'({lvl_b, lvl_a}), 8'h01);
    chk(8'(pin4_oe), 8'h01);
    chk(8'(pin4), 8'h01);
    $display("jump test done");
  endtask
  task automatic t_play;
    int t0;
    t0 = ticks;
    press[2] <= 1'b1;
    wait_n(30);
    chk(8'(playing), 8'h01);
    chk(8'(rate), 8'h03);
    chk(8'(lamp1), 8'h01);
    for (int i = 0; i < 70000 && playing !== 1'b0; i++)
      @(posedge clk);
    chk(8'(ticks - t0), 8'h02);
    $display("playback test done");
  endtask
  task automatic t_abort;
    int n_lamp;
    int n_pin4;
    n_lamp = 0;
    n_pin4 = 0;
    press[2] <= 1'b0;
    wait_n(30);
    chk(8'(playing), 8'h01);
    // flash phase runs free, so any window of two half periods is half lit
    repeat (2 * FLASH_HALF)
    begin
      @(posedge clk);
      n_lamp += int'(lamp1);
      n_pin4 += int'(pin4);
    end
    chk(8'(n_lamp), 8'(FLASH_HALF));
    chk(8'(n_pin4), 8'(FLASH_HALF));
    press[0] <= 1'b0;
    wait_n(30);
    chk(8'(playing), 8'h00);
    chk(8'({lvl_b, lvl_a}), 8'h03);
    $display("abort test done");
  endtask
  // short debounce is active here, so a six-cycle press must be taken
  task automatic t_mask;
    press[1] <= 1'b1;
    wait_n(30);
    chk(8'({lvl_b, lvl_a}), 8'h03);
    press[0] <= 1'b1;
    wait_n(6);
    press[0] <= 1'b0;
    wait_n(30);
    chk(8'({lvl_b, lvl_a}), 8'h01);
    chk(8'(pin4), 8'h01);
    $display("mask test done");
  endtask
  initial
  begin
    wait_n(6);
    rst_b <= 1'b1;
    t_load();
    t_por();
    t_jump();
    t_play();
    t_abort();
    t_mask();
    print_verdict();
  end
endmodule // tb_top
